/* tb_usb_device_in_endpoint_tx.sv */
// Testbench for the IN endpoint transmit block
`timescale 1ns/10ps
`default_nettype none
module tb_usb_device_in_endpoint_tx
  import uit_pkg::*;
;
  logic           mclk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0]     htrans = 2'h0;
  logic [2:0]     hsize = 3'h2;
  logic [31:0]    haddr = 32'h0, hwdata = 32'h0, hrdata, d, w0;
  logic           hreadyout, hresp, irq, tok_valid, tx_ready, ack_rcvd, ack_timeout;
  logic           tx_valid, hs_nak;
  logic [EPW-1:0] tok_ep;
  uit_txd_t       tx_word;
  int             fails = 0, num_checks = 0, cyc = 0, nb;
  bit             nk;

  always #2.5 mclk = ~mclk;

  uit_top DUT (
    .mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .irq(irq),
    .tok_valid(tok_valid), .tok_ep(tok_ep), .tx_ready(tx_ready), .ack_rcvd(ack_rcvd),
    .ack_timeout(ack_timeout), .tx_valid(tx_valid), .tx_word(tx_word), .hs_nak(hs_nak)
  );
  uit_host host (
    .mclk(mclk), .tx_valid(tx_valid), .tx_word(tx_word), .hs_nak(hs_nak),
    .tok_valid(tok_valid), .tok_ep(tok_ep), .tx_ready(tx_ready),
    .ack_rcvd(ack_rcvd), .ack_timeout(ack_timeout)
  );

  task automatic close_out;
    if (fails == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask

  function automatic logic [31:0] b(input logic v);
    return {31'h0, v};
  endfunction
  function automatic logic [31:0] ea(input logic e, input logic [3:0] o);
    return {26'h0, 1'b1, e, o};
  endfunction
  function automatic logic [31:0] tz(input int s, input int p, input int m);
    return {1'b0, 2'(m), 10'(p), 19'(s)};
  endfunction

  // One single transfer; hready is sampled before anything is released
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] rv);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    logic [31:0] x;
    bus(a, 1'b1, v, x);
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] v);
    bus(a, 1'b0, 32'h0, v);
  endtask

  task automatic ep_go(input logic e, input logic [31:0] t, input logic [1:0] ty,
                       input logic [10:0] m);
    wr(ea(e, 4'h4), t);
    wr(ea(e, 4'h0), 32'h8400_0000 | {12'h0, ty, 18'h0} | {21'h0, m});
  endtask
  task automatic put(input logic e, input logic [10:0] len, input logic [31:0] v);
    for (int i = 0; i < (int'(len) + 3) / 4; i++) wr(32'h08, v + i);
    wr(32'h0C, {15'h0, e, 5'h0, len});
  endtask

  task automatic s_idle;
    rd(32'h20, d);
    chk("ctl0 reset", 32'h0002_0000, d);
    rd(32'h80, d);
    chk("unmapped read", 32'h0, d);
    chk("hresp okay", 32'h0, b(hresp));
    ep_go(1'b0, 32'h0, 2'h0, 11'h40);
    host.poll(1'b0, 1'b0, 1, nk, nb, w0);
    chk("nak empty", 32'hFFFF_FFFF, 32'(nb));
    rd(32'h00, d);
    chk("token flag", 32'h1, b(d[2]));
    chk("irq masked", 32'h0, b(irq));
    wr(32'h04, 32'h4);
    repeat (3) @(posedge mclk);
    chk("irq raised", 32'h1, b(irq));
    wr(32'h00, 32'h4);
    repeat (3) @(posedge mclk);
    chk("irq cleared", 32'h0, b(irq));
    wr(32'h04, 32'h0);
  endtask

  task automatic s_single;
    ep_go(1'b0, tz(10, 1, 0), 2'h0, 11'h40);
    put(1'b0, 11'd10, 32'hA5A5_0000);
    rd(ea(1'b0, 4'h4), d);
    chk("size after commit", tz(0, 1, 0), d);
    host.poll(1'b0, 1'b1, 1, nk, nb, w0);
    chk("bytes sent", 32'd10, 32'(nb));
    chk("first word", 32'hA5A5_0000, w0);
    repeat (3) @(posedge mclk);
    rd(32'h00, d);
    chk("complete ep0", 32'h1, b(d[1]));
    rd(ea(1'b0, 4'h0), d);
    chk("enable cleared", 32'h0, b(d[31]));
  endtask

  task automatic s_two;
    wr(32'h00, 32'h1F);
    ep_go(1'b1, tz(6, 1, 0), 2'h0, 11'h40);
    ep_go(1'b0, tz(4, 1, 0), 2'h0, 11'h40);
    put(1'b1, 11'd6, 32'hB000_0000);
    put(1'b0, 11'd4, 32'hC000_0000);
    host.poll(1'b0, 1'b0, 1, nk, nb, w0);
    chk("head is ep1", 32'h1, b(nk));
    host.poll(1'b1, 1'b0, 2, nk, nb, w0);
    host.poll(1'b1, 1'b0, 1, nk, nb, w0);
    chk("retry bytes", 32'd6, 32'(nb));
    repeat (3) @(posedge mclk);
    rd(32'h00, d);
    chk("ep1 done only", 32'h8, d & 32'hA);
    host.poll(1'b0, 1'b0, 1, nk, nb, w0);
    chk("ep0 word", 32'hC000_0000, w0);
    repeat (3) @(posedge mclk);
    rd(32'h00, d);
    chk("both done", 32'hA, d & 32'hA);
  endtask

  task automatic s_half;
    ep_go(1'b0, tz(132, 1, 0), 2'h0, 11'h200);
    put(1'b0, 11'd132, 32'hD000_0000);
    rd(32'h10, d);
    chk("space", 32'd31, d);
    wr(32'h00, 32'h1);
    @(posedge mclk);
    rd(32'h00, d);
    chk("not below half", 32'h0, b(d[0]));
    host.poll(1'b0, 1'b0, 1, nk, nb, w0);
    chk("long packet", 32'd132, 32'(nb));
    rd(32'h00, d);
    chk("below half", 32'h1, b(d[0]));
  endtask

  task automatic s_iso;
    wr(32'h00, 32'h1F);
    ep_go(1'b1, tz(5, 2, 2), 2'h1, 11'h4);
    put(1'b1, 11'd4, 32'hE000_0000);
    put(1'b1, 11'd1, 32'hF000_0000);
    host.poll(1'b1, 1'b0, 0, nk, nb, w0);
    chk("iso full", 32'd4, 32'(nb));
    host.poll(1'b1, 1'b1, 0, nk, nb, w0);
    chk("iso short", 32'd1, 32'(nb));
    repeat (3) @(posedge mclk);
    rd(32'h00, d);
    chk("iso done", 32'h1, b(d[3]));
    ep_go(1'b1, tz(0, 1, 1), 2'h1, 11'h4);
    put(1'b1, 11'd0, 32'h0);
    host.poll(1'b1, 1'b0, 0, nk, nb, w0);
    chk("zero length", 32'h0, 32'(nb));
  endtask

  // Whole run needs a few hundred cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      close_out();
    end
  end

  initial begin
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    s_idle();
    s_single();
    s_two();
    s_half();
    s_iso();
    close_out();
  end
endmodule
`default_nettype wire

/* uit_chk.sv */
// Checker of the IN transmit port behaviour
`timescale 1ns/10ps
`default_nettype none
module uit_chk
  import uit_pkg::*;
(
  input wire logic     mclk,
  input wire logic     rstn,
  input wire logic     irq,
  input wire logic     tok_valid,
  input wire logic     tx_ready,
  input wire logic     ack_rcvd,
  input wire logic     tx_valid,
  input wire uit_txd_t tx_word,
  input wire logic     hs_nak
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  nak_nodata_a: assert property (hs_nak |-> !tx_valid)
    else $error("NAK sent with data offered");
  nak_cause_a: assert property (hs_nak |-> $past(tok_valid))
    else $error("NAK without a token");
  nak_pulse_a: assert property (hs_nak |=> !hs_nak)
    else $error("NAK longer than one cycle");
  word_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_word))
    else $error("Offered word changed before taken");
  zlp_last_a: assert property (tx_valid && tx_word.zlp |-> tx_word.last)
    else $error("Zero length word not last");
  full_words_a: assert property (tx_valid && !tx_word.last |-> tx_word.bytes == 3'h4)
    else $error("Short word before packet end");
  pkt_end_a: assert property (tx_valid && tx_ready && tx_word.last && !tok_valid |=> !tx_valid)
    else $error("Data after last word");
  ack_quiet_a: assert property (ack_rcvd && !tok_valid |=> !tx_valid)
    else $error("Data without a token");
  irq_reset_a: assert property ($rose(rstn) |-> !irq ##1 !irq)
    else $error("Interrupt with mask at reset");
  cover property (hs_nak);
  cover property (tx_valid && tx_word.zlp);
  cover property (ack_rcvd);
  cover property (irq);
endmodule
bind uit_top uit_chk u_chk (
  .mclk(mclk), .rstn(rstn), .irq(irq), .tok_valid(tok_valid), .tx_ready(tx_ready),
  .ack_rcvd(ack_rcvd), .tx_valid(tx_valid), .tx_word(tx_word), .hs_nak(hs_nak)
);
`default_nettype wire

/* uit_ep.sv */
// Per-endpoint control, transfer size and address registers
`timescale 1ns/10ps
`default_nettype none
module uit_ep
  import uit_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic             rstn,
  input  wire logic             wr_ctl,
  input  wire logic             wr_tsiz,
  input  wire logic             wr_dma,
  input  wire logic [31:0]      wdata,
  input  wire logic             commit,
  input  wire logic [LEN_W-1:0] commit_len,
  input  wire logic             done,
  output logic      [31:0]      ctl_rd,
  output logic      [31:0]      tsiz_rd,
  output logic      [31:0]      dma_rd,
  output logic                  nak,
  output logic                  iso,
  output logic                  cmpl
);
  logic              en_r, en_nxt, nak_r, nak_nxt;
  logic [1:0]        typ_r, typ_nxt, ppf_r, ppf_nxt;
  logic [LEN_W-1:0]  mps_r, mps_nxt;
  logic [XFER_W-1:0] xfer_r, xfer_nxt;
  logic [PKT_W-1:0]  pkt_r, pkt_nxt;
  logic [31:0]       dma_r, dma_nxt;

  assign ctl_rd  = {en_r, 11'h000, typ_r, nak_r, 6'h00, mps_r};
  assign tsiz_rd = {1'b0, ppf_r, pkt_r, xfer_r};
  assign dma_rd  = dma_r;
  assign nak     = nak_r;
  assign iso     = (typ_r == EPTYPE_ISO);

  always_comb begin
    en_nxt   = en_r;
    nak_nxt  = nak_r;
    typ_nxt  = typ_r;
    mps_nxt  = mps_r;
    xfer_nxt = xfer_r;
    pkt_nxt  = pkt_r;
    ppf_nxt  = ppf_r;
    dma_nxt  = wr_dma ? wdata : dma_r;
    cmpl     = 1'b0;
    if (wr_ctl) begin
      en_nxt  = wdata[CTL_EN];
      typ_nxt = wdata[CTL_TYPE_LO +: 2];
      mps_nxt = wdata[LEN_W-1:0];
      if (wdata[CTL_CLR_NAK]) begin
        nak_nxt = 1'b0;
      end
      if (wdata[CTL_SNAK]) begin
        nak_nxt = 1'b1;
      end
    end
    if (wr_tsiz) begin
      xfer_nxt = wdata[XFER_W-1:0];
      pkt_nxt  = wdata[TSIZ_PKT_LO +: PKT_W];
      ppf_nxt  = wdata[TSIZ_PPF_LO +: 2];
    end
    if (commit) begin
      // Saturate so a careless oversize packet cannot wrap the remaining size
      xfer_nxt = (xfer_r > XFER_W'(commit_len)) ? XFER_W'(xfer_r - XFER_W'(commit_len))
                                                  : '0;
    end
    if (done && pkt_r != '0) begin
      pkt_nxt = PKT_W'(pkt_r - 1'b1);
    end
    if (done && en_r && xfer_nxt == '0 && pkt_nxt == '0) begin
      cmpl   = 1'b1;
      en_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      en_r   <= 1'b0;
      nak_r  <= 1'b1;
      typ_r  <= '0;
      mps_r  <= '0;
      xfer_r <= '0;
      pkt_r  <= '0;
      ppf_r  <= '0;
      dma_r  <= REG_RST;
    end else begin
      en_r   <= en_nxt;
      nak_r  <= nak_nxt;
      typ_r  <= typ_nxt;
      mps_r  <= mps_nxt;
      xfer_r <= xfer_nxt;
      pkt_r  <= pkt_nxt;
      ppf_r  <= ppf_nxt;
      dma_r  <= dma_nxt;
    end
  end
endmodule
`default_nettype wire

/* uit_fifo.sv */
// Flop FIFO with offset peek and multi-entry pop
`timescale 1ns/10ps
`default_nettype none
module uit_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  input  wire logic          mclk,
  input  wire logic          rstn,
  input  wire logic          push,
  input  wire logic [W-1:0]  din,
  input  wire logic          pop,
  input  wire logic [AW:0]   pop_n,
  input  wire logic [AW-1:0] peek_ofs,
  output logic      [W-1:0]  peek,
  output logic               full,
  output logic               empty,
  output logic      [AW:0]   level
);
  logic [W-1:0]  mem_r [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]   lvl_r, lvl_nxt;
  logic          do_push;

  // Peek never wraps past write pointer as long as offset stays below level
  assign peek    = mem_r[AW'(rp_r + peek_ofs)];
  assign full    = (lvl_r == (AW+1)'(DEPTH));
  assign empty   = (lvl_r == '0);
  assign level   = lvl_r;
  assign do_push = push && !full;

  always_comb begin
    wp_nxt  = do_push ? AW'(wp_r + 1'b1) : wp_r;
    rp_nxt  = pop ? AW'(rp_r + pop_n[AW-1:0]) : rp_r;
    lvl_nxt = (AW+1)'(lvl_r + {{AW{1'b0}}, do_push} - (pop ? pop_n : '0));
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wp_r  <= '0;
      rp_r  <= '0;
      lvl_r <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      lvl_r <= lvl_nxt;
    end
  end

  // Storage carries no reset: only the pointers define what is valid
  always_ff @(posedge mclk) begin
    if (do_push) begin
      mem_r[wp_r] <= din;
    end
  end
endmodule
`default_nettype wire

/* uit_host.sv */
// Host model issuing IN tokens and handshakes
`timescale 1ns/10ps
`default_nettype none
module uit_host
  import uit_pkg::*;
(
  input  wire logic           mclk,
  input  wire logic           tx_valid,
  input  wire uit_txd_t       tx_word,
  input  wire logic           hs_nak,
  output logic                tok_valid = 1'b0,
  output logic      [EPW-1:0] tok_ep = '0,
  output logic                tx_ready = 1'b0,
  output logic                ack_rcvd = 1'b0,
  output logic                ack_timeout = 1'b0
);
  // Handshake hs: 0 none (iso), 1 ACK, 2 lost; nb stays -1 on NAK
  task automatic poll(input logic e, input bit slow, input int hs,
                      output bit nk, output int nb, output logic [31:0] w0);
    nk = 1'b0;
    nb = -1;
    w0 = 32'h0;
    tok_valid <= 1'b1;
    tok_ep    <= e;
    tx_ready  <= !slow;
    @(posedge mclk);
    tok_valid <= 1'b0;
    tok_ep    <= ~e;  // Idle lines must not keep the old value
    for (int i = 0; i < 300; i++) begin
      @(posedge mclk);
      if (hs_nak === 1'b1) begin
        nk = 1'b1;
        break;
      end
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
        if (nb < 0) begin
          nb = 0;
          w0 = tx_word.data;
        end
        if (!tx_word.zlp) nb += int'(tx_word.bytes);
        if (tx_word.last) break;
      end
      if (slow) tx_ready <= ~tx_ready;
    end
    tx_ready <= 1'b0;
    if (!nk && hs != 0) begin
      @(posedge mclk);
      ack_rcvd    <= (hs == 1);
      ack_timeout <= (hs == 2);
      @(posedge mclk);
      ack_rcvd    <= 1'b0;
      ack_timeout <= 1'b0;
    end
    repeat (2) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

/* uit_pkg.sv */
// Shared constants and types for the USB IN endpoint transmit block
// How it works
// - An IN token with no data for a non-isochronous endpoint is answered with NAK only.
// - An IN token that finds no data sets the endpoint's token-while-empty flag.
// - A packet at the head of the shared queue for the addressed endpoint is sent; the host ACK is taken unless isochronous.
// - Transfer-complete is flagged once the last packet is acknowledged (sent, if isochronous) and the size is zero.
// - The shared FIFO half-empty interrupt is raised while the fill level is below half.
// - Every endpoint keeps its own size, count and completion flag.
// - A periodic transfer shorter than its frame quota ends with a short packet.
// - Each packet written to the FIFO reduces the remaining size by its length.
// - Size and count both zero raises transfer-complete and clears endpoint enable.
package uit_pkg;
  localparam int N_EP     = 2;
  localparam int EPW      = 1;
  localparam int WF_DEPTH = 64;
  localparam int WF_AW    = 6;
  localparam int PQ_DEPTH = 8;
  localparam int PQ_AW    = 3;
  localparam int LEN_W    = 11;
  localparam int XFER_W   = 19;
  localparam int PKT_W    = 10;
  localparam int ST_W     = 1 + 2 * N_EP;

  localparam logic [7:0] A_INT_STS     = 8'h00;
  localparam logic [7:0] A_INT_MSK     = 8'h04;
  localparam logic [7:0] A_FIFO_DATA   = 8'h08;
  localparam logic [7:0] A_FIFO_COMMIT = 8'h0C;
  localparam logic [7:0] A_FIFO_SPACE  = 8'h10;
  localparam logic [7:0] A_EP_BASE     = 8'h20;
  localparam logic [7:0] A_EP_END      = 8'h40;
  localparam logic [3:0] EP_CTL        = 4'h0;
  localparam logic [3:0] EP_TSIZ       = 4'h4;
  localparam logic [3:0] EP_DMA        = 4'h8;

  localparam int CTL_EN      = 31;
  localparam int CTL_SNAK    = 27;
  localparam int CTL_CLR_NAK = 26;
  localparam int CTL_TYPE_LO = 18;
  localparam int CTL_NAKSTS  = 17;
  localparam int TSIZ_PKT_LO = 19;
  localparam int TSIZ_PPF_LO = 29;
  localparam int COMMIT_EP   = 16;
  localparam int ST_HALF     = 0;

  localparam logic [1:0]      EPTYPE_ISO = 2'h1;
  localparam logic [ST_W-1:0] MSK_RST    = 5'h00;
  localparam logic [31:0]     REG_RST    = 32'h0000_0000;

  typedef struct packed {
    logic [EPW-1:0]   ep;
    logic [LEN_W-1:0] len;
  } uit_pkt_t;

  typedef struct packed {
    logic [31:0] data;
    logic [2:0]  bytes;
    logic        last;
    logic        zlp;
  } uit_txd_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_SEND = 3'b010,
    S_WACK = 3'b100
  } uit_st_t;
endpackage

/* uit_top.sv */
// IN endpoint transmit engine with AHB-Lite register slave
//
// Our own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
module uit_top
  import uit_pkg::*;
(
  input  wire logic           mclk,
  input  wire logic           rstn,
  input  wire logic           hsel,
  input  wire logic [31:0]    haddr,
  input  wire logic [1:0]     htrans,
  input  wire logic           hwrite,
  input  wire logic [2:0]     hsize,
  input  wire logic [31:0]    hwdata,
  input  wire logic           hready,
  output logic                hreadyout,
  output logic      [31:0]    hrdata,
  output logic                hresp,
  output logic                irq,
  input  wire logic           tok_valid,
  input  wire logic [EPW-1:0] tok_ep,
  input  wire logic           tx_ready,
  input  wire logic           ack_rcvd,
  input  wire logic           ack_timeout,
  output logic                tx_valid,
  output uit_txd_t            tx_word,
  output logic                hs_nak
);
  // Bus slave state
  logic            wr_pend_r, wr_pend_nxt;
  logic [7:0]      waddr_r, waddr_nxt;
  logic [31:0]     hrdata_r, hrdata_nxt;
  logic            aphase;
  logic            wr_sts, wr_msk, wr_data, wr_commit, wr_ep;
  logic [EPW-1:0]  wr_idx;

  // Interrupt state
  logic [ST_W-1:0] sts_r, sts_nxt, msk_r, msk_nxt, sts_set;
  logic            irq_r, irq_nxt;

  // Endpoint views
  logic [31:0]     ep_ctl [N_EP];
  logic [31:0]     ep_tsiz [N_EP];
  logic [31:0]     ep_dma [N_EP];
  logic [N_EP-1:0] ep_nak, ep_iso, ep_cmpl;

  // FIFOs
  uit_pkt_t        pq_head, pq_din;
  logic            pq_full, pq_empty, pq_push;
  logic [31:0]     wf_peek;
  logic [WF_AW:0]  wf_level;
  logic [WF_AW:0]  wf_pop_n;
  logic [WF_AW-1:0] ofs_nxt;

  // Transmit state
  uit_st_t         st_r, st_nxt;
  logic [EPW-1:0]  cur_ep_r, cur_ep_nxt;
  logic [LEN_W-1:0] cur_len_r, cur_len_nxt;
  logic [WF_AW:0]  nw_r, nw_nxt;
  logic [WF_AW-1:0] ofs_r;
  logic            real_r, real_nxt;
  uit_txd_t        txd_r, txd_nxt;
  logic            txv_r, txv_nxt, nak_r, nak_nxt;
  logic            done;
  logic [N_EP-1:0] tkn_set;
  logic [11:0]     wsum;
  logic [2:0]      tail_bytes;
  logic            head_hit;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;
  assign irq       = irq_r;
  assign tx_valid  = txv_r;
  assign tx_word   = txd_r;
  assign hs_nak    = nak_r;

  // Zero wait states: every access finishes in its first data-phase cycle
  assign aphase    = hsel && htrans[1] && hready;
  assign wr_sts    = wr_pend_r && waddr_r == A_INT_STS;
  assign wr_msk    = wr_pend_r && waddr_r == A_INT_MSK;
  assign wr_data   = wr_pend_r && waddr_r == A_FIFO_DATA;
  assign wr_commit = wr_pend_r && waddr_r == A_FIFO_COMMIT;
  assign wr_ep     = wr_pend_r && waddr_r >= A_EP_BASE && waddr_r < A_EP_END;
  assign wr_idx    = waddr_r[4 +: EPW];
  assign pq_din    = '{ep: hwdata[COMMIT_EP +: EPW], len: hwdata[LEN_W-1:0]};
  assign pq_push   = wr_commit && !pq_full;

  always_comb begin
    wr_pend_nxt = aphase && hwrite;
    waddr_nxt   = aphase ? haddr[7:0] : waddr_r;
    hrdata_nxt  = '0;
    if (aphase && !hwrite) begin
      case (haddr[7:0])
        A_INT_STS:    hrdata_nxt = 32'(sts_r);
        A_INT_MSK:    hrdata_nxt = 32'(msk_r);
        A_FIFO_SPACE: hrdata_nxt = 32'(WF_DEPTH) - 32'(wf_level);
        default: begin
          if (haddr[7:0] >= A_EP_BASE && haddr[7:0] < A_EP_END) begin
            case (haddr[3:0])
              EP_CTL:  hrdata_nxt = ep_ctl[haddr[4 +: EPW]];
              EP_TSIZ: hrdata_nxt = ep_tsiz[haddr[4 +: EPW]];
              EP_DMA:  hrdata_nxt = ep_dma[haddr[4 +: EPW]];
              default: hrdata_nxt = '0;
            endcase
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wr_pend_r <= 1'b0;
      waddr_r   <= '0;
      hrdata_r  <= REG_RST;
    end else begin
      wr_pend_r <= wr_pend_nxt;
      waddr_r   <= waddr_nxt;
      hrdata_r  <= hrdata_nxt;
    end
  end

  // Shared FIFO: data words, and a packet queue that fixes the write order
  uit_fifo #(.W(32), .DEPTH(WF_DEPTH), .AW(WF_AW)) u_wf (
    .mclk     (mclk),
    .rstn     (rstn),
    .push     (wr_data),
    .din      (hwdata),
    .pop      (done),
    .pop_n    (wf_pop_n),
    .peek_ofs (ofs_nxt),
    .peek     (wf_peek),
    .full     (),
    .empty    (),
    .level    (wf_level)
  );

  uit_fifo #(.W($bits(uit_pkt_t)), .DEPTH(PQ_DEPTH), .AW(PQ_AW)) u_pq (
    .mclk     (mclk),
    .rstn     (rstn),
    .push     (pq_push),
    .din      (pq_din),
    .pop      (done),
    .pop_n    ((PQ_AW+1)'(1)),
    .peek_ofs ('0),
    .peek     (pq_head),
    .full     (pq_full),
    .empty    (pq_empty),
    .level    ()
  );

  genvar gi;
  generate
    for (gi = 0; gi < N_EP; gi++) begin : g_ep
      uit_ep u_ep (
        .mclk       (mclk),
        .rstn       (rstn),
        .wr_ctl     (wr_ep && wr_idx == EPW'(gi) && waddr_r[3:0] == EP_CTL),
        .wr_tsiz    (wr_ep && wr_idx == EPW'(gi) && waddr_r[3:0] == EP_TSIZ),
        .wr_dma     (wr_ep && wr_idx == EPW'(gi) && waddr_r[3:0] == EP_DMA),
        .wdata      (hwdata),
        .commit     (pq_push && pq_din.ep == EPW'(gi)),
        .commit_len (pq_din.len),
        .done       (done && cur_ep_r == EPW'(gi)),
        .ctl_rd     (ep_ctl[gi]),
        .tsiz_rd    (ep_tsiz[gi]),
        .dma_rd     (ep_dma[gi]),
        .nak        (ep_nak[gi]),
        .iso        (ep_iso[gi]),
        .cmpl       (ep_cmpl[gi])
      );
    end
  endgenerate

  // Head of the shared queue must belong to the addressed endpoint
  assign head_hit   = !pq_empty && pq_head.ep == tok_ep && !ep_nak[tok_ep];
  assign wsum       = 12'({1'b0, pq_head.len} + 12'h003);
  assign tail_bytes = (cur_len_r[1:0] == 2'h0) ? 3'h4 : {1'b0, cur_len_r[1:0]};
  assign wf_pop_n   = nw_r;

  always_comb begin
    st_nxt      = st_r;
    cur_ep_nxt  = cur_ep_r;
    cur_len_nxt = cur_len_r;
    nw_nxt      = nw_r;
    real_nxt    = real_r;
    ofs_nxt     = ofs_r;
    txd_nxt     = txd_r;
    txv_nxt     = txv_r;
    nak_nxt     = 1'b0;
    done        = 1'b0;
    tkn_set     = '0;
    case (st_r)
      S_IDLE: begin
        ofs_nxt = '0;
        if (tok_valid) begin
          cur_ep_nxt = tok_ep;
          if (head_hit) begin
            cur_len_nxt = pq_head.len;
            nw_nxt      = wsum[WF_AW+2:2];
            real_nxt    = 1'b1;
            txv_nxt     = 1'b1;
            txd_nxt     = '{data: (pq_head.len == '0) ? 32'h0000_0000 : wf_peek,
                            bytes: (pq_head.len == '0) ? 3'h0 :
                                   (wsum[WF_AW+2:2] == (WF_AW+1)'(1)) ?
                                   ((pq_head.len[1:0] == 2'h0) ? 3'h4 :
                                    {1'b0, pq_head.len[1:0]}) : 3'h4,
                            last: wsum[WF_AW+2:2] <= (WF_AW+1)'(1),
                            zlp: pq_head.len == '0};
            st_nxt      = S_SEND;
          end else begin
            tkn_set[tok_ep] = 1'b1;
            if (ep_iso[tok_ep] && !ep_nak[tok_ep]) begin
              real_nxt = 1'b0;
              nw_nxt   = '0;
              txv_nxt  = 1'b1;
              txd_nxt  = '{data: 32'h0000_0000, bytes: 3'h0, last: 1'b1, zlp: 1'b1};
              st_nxt   = S_SEND;
            end else begin
              nak_nxt = 1'b1;
            end
          end
        end
      end
      S_SEND: begin
        if (tx_ready) begin
          if (txd_r.last) begin
            txv_nxt = 1'b0;
            ofs_nxt = '0;
            if (ep_iso[cur_ep_r]) begin
              // No handshake on isochronous: count the packet once it is out
              done   = real_r;
              st_nxt = S_IDLE;
            end else begin
              st_nxt = S_WACK;
            end
          end else begin
            ofs_nxt = WF_AW'(ofs_r + 1'b1);
            txd_nxt = '{data: wf_peek,
                        bytes: ((WF_AW+1)'(ofs_nxt) == nw_r - 1'b1) ? tail_bytes : 3'h4,
                        last: (WF_AW+1)'(ofs_nxt) == nw_r - 1'b1,
                        zlp: 1'b0};
          end
        end
      end
      S_WACK: begin
        if (ack_rcvd) begin
          done   = 1'b1;
          st_nxt = S_IDLE;
        end else if (ack_timeout) begin
          // Data stays queued so the host's retry gets the same packet
          st_nxt = S_IDLE;
        end
      end
      default: begin
        st_nxt  = S_IDLE;
        txv_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_r      <= S_IDLE;
      cur_ep_r  <= '0;
      cur_len_r <= '0;
      nw_r      <= '0;
      real_r    <= 1'b0;
      ofs_r     <= '0;
      txd_r     <= '0;
      txv_r     <= 1'b0;
      nak_r     <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      cur_ep_r  <= cur_ep_nxt;
      cur_len_r <= cur_len_nxt;
      nw_r      <= nw_nxt;
      real_r    <= real_nxt;
      ofs_r     <= ofs_nxt;
      txd_r     <= txd_nxt;
      txv_r     <= txv_nxt;
      nak_r     <= nak_nxt;
    end
  end

  // Sticky status, write one to clear; a new event in the same cycle wins
  always_comb begin
    sts_set          = '0;
    sts_set[ST_HALF] = wf_level < (WF_AW+1)'(WF_DEPTH / 2);
    for (int i = 0; i < N_EP; i++) begin
      sts_set[1 + 2*i] = ep_cmpl[i];
      sts_set[2 + 2*i] = tkn_set[i];
    end
    sts_nxt = (sts_r & ~(wr_sts ? hwdata[ST_W-1:0] : '0)) | sts_set;
    msk_nxt = wr_msk ? hwdata[ST_W-1:0] : msk_r;
    irq_nxt = |(sts_nxt & msk_nxt);
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sts_r <= '0;
      msk_r <= MSK_RST;
      irq_r <= 1'b0;
    end else begin
      sts_r <= sts_nxt;
      msk_r <= msk_nxt;
      irq_r <= irq_nxt;
    end
  end
endmodule
`default_nettype wire
